/* rtl/modbus_crc16.sv */
// Byte-serial CRC-16 engine, one byte per cycle
`timescale 1ns/1ps
`include "modbus_frame_regs.svh"
module modbus_crc16 (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        ce,
    input  wire logic        restart,   // Next byte starts a new frame
    input  wire logic        en,        // Fold data into the sum
    input  wire logic [7:0]  data,
    output logic      [15:0] crc_q,
    output logic      [15:0] crc_d      // Sum including data
);
    // Reflected polynomial, eight shifts per byte
    always_comb begin
        logic [15:0] c;
        c = restart ? `CRC_INIT : crc_q;
        c = c ^ {8'h00, data};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ `CRC_POLY) : (c >> 1);
        end
        crc_d = c;
    end

    // Running sum register
    always_ff @(posedge clk) begin
        if (reset) begin
            crc_q <= `CRC_INIT;
        end else if (ce && en) begin
            crc_q <= crc_d;
        end
    end
endmodule

/* rtl/modbus_frame_pkg.sv */
// Types shared by the RTU slave frame handler
package modbus_frame_pkg;
    typedef enum logic [2:0] {ST_RX, ST_DECODE, ST_NVWAIT, ST_DELAY, ST_SEND} state_t;
    typedef enum logic [1:0] {RP_ECHO, RP_READ, RP_EXC} reply_t;
endpackage

/* rtl/modbus_frame_regs.svh */
// Offsets, codes and timing constants for the RTU slave frame handler
`ifndef MODBUS_FRAME_REGS_SVH
`define MODBUS_FRAME_REGS_SVH
`define FC_READ        8'h03
`define FC_WRITE_NV    8'h06
`define FC_LOOP        8'h08
`define FC_WRITE       8'h41
`define FC_EXC_BIT     8'h80
`define EX_NONE        8'h00
`define EX_ILL_FUNC    8'h01
`define EX_ILL_ADDR    8'h02
`define EX_BAD_FRAME   8'h03
`define EX_SLAVE_PROT  8'h04
`define EX_RANGE       8'h05
`define EX_READ_ONLY   8'h06
`define EX_RUNNING     8'h07
`define EX_PASSWORD    8'h08
`define ADDR_CARRIER   16'h0017
`define ADDR_FAULT0    16'h1300
`define ADDR_FAULT_END 17'h01306
`define ADDR_CMD       16'h7000
`define ADDR_FREQ      16'h7015
`define LOOP_SUB       16'h0000
`define CMD_FWD        16'h0001
`define CMD_COAST      16'h0007
`define FREQ_SRC_COMM  4'h7
`define BCAST_ADDR     8'h00
`define MIN_LEN        4'h3
`define REQ_LEN        4'h8
`define REQ_LEN5       5'h08
`define EXC_LEN        5'h05
`define READ_OVERHEAD  5'h05
`define TURNAROUND_MS  17'h00001
`define CRC_INIT       16'hFFFF
`define CRC_POLY       16'hA001
`define CARRIER_RESET  16'h0000
`endif

/* rtl/modbus_rtu_slave_frames.sv */
// RTU slave frame handler: receive, qualify, execute, reply
`timescale 1ns/1ps
`include "modbus_frame_regs.svh"
module modbus_rtu_slave_frames import modbus_frame_pkg::*; (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic        ce,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_data,
    input  wire logic        rx_from_keypad,
    input  wire logic        ms_tick,
    input  wire logic [7:0]  slave_address,
    input  wire logic [3:0]  eof_gap_ms,
    input  wire logic [3:0]  fault_gap_ms,
    input  wire logic [15:0] comm_timeout_setting,
    input  wire logic [15:0] response_delay_setting,
    input  wire logic [3:0]  main_frequency_source_select,
    input  wire logic [95:0] fault_info,
    input  wire logic        drive_running,
    input  wire logic        nv_done,
    input  wire logic        nv_fail,
    input  wire logic        tx_ready,
    output logic             tx_valid_q,
    output logic      [7:0]  tx_data_q,
    output logic             nv_store_q,
    output logic      [15:0] nv_addr_q,
    output logic      [15:0] nv_data_q,
    output logic      [15:0] carrier_frequency_q,
    output logic      [15:0] drive_control_command_q,
    output logic             cmd_strobe_q,
    output logic      [15:0] comm_set_frequency_q,
    output logic             comm_freq_in_use_q,
    output logic             comm_timeout_q,
    output logic             rx_gap_fault_q
);
    state_t      st_q;                      // Frame handler state
    reply_t      kind_q;                    // Reply shape
    logic [7:0]  buf_q [0:7];               // Request bytes
    logic [3:0]  cnt_q;                     // Bytes seen, stops at nine
    logic [3:0]  gap_q;                     // Idle ms since last byte
    logic        bad_q;                     // Inner gap seen
    logic        keypad_q;                  // Any byte from keypad
    logic [4:0]  len_q;                     // Reply length
    logic [4:0]  idx_q;                     // Reply byte on the line
    logic [7:0]  exc_q;                     // Exception code
    logic [16:0] dly_q;                     // Reply delay in ms
    logic [15:0] to_cnt_q;                  // Ms since last valid frame
    logic [15:0] rx_crc, rx_crc_d, tx_crc, tx_crc_d;
    logic [7:0]  func, nb;
    logic [15:0] reg_addr, reg_val;
    logic        legal, bcast, crc_ok, len_ok, known, valid, fault_rng;
    logic        eof, gap_fault, hs, last;
    logic [7:0]  exc_d;
    logic [16:0] dly_lim;

    assign func     = buf_q[1];
    assign reg_addr = {buf_q[2], buf_q[3]};
    assign reg_val  = {buf_q[4], buf_q[5]};
    assign hs       = tx_valid_q && tx_ready;
    assign last     = idx_q == len_q - 5'h01;
    assign dly_lim  = {1'b0, response_delay_setting} + `TURNAROUND_MS;

    // Frame end after long idle, fault on inner idle
    assign eof = st_q == ST_RX && !rx_valid && ms_tick && cnt_q != 4'h0
              && ({1'b0, gap_q} + 5'h01) >= {1'b0, eof_gap_ms};
    assign gap_fault = st_q == ST_RX && rx_valid && cnt_q != 4'h0
                    && gap_q >= fault_gap_ms;

    // Residue of zero over data plus CRC means a good frame
    modbus_crc16 u_rx_crc (
        .clk     (clk),
        .reset   (reset),
        .ce      (ce),
        .restart (cnt_q == 4'h0),
        .en      (st_q == ST_RX && rx_valid),
        .data    (rx_data),
        .crc_q   (rx_crc),
        .crc_d   (rx_crc_d)
    );

    // Reply CRC folds every byte before the two check bytes
    modbus_crc16 u_tx_crc (
        .clk     (clk),
        .reset   (reset),
        .ce      (ce),
        .restart (idx_q == 5'h00),
        .en      (hs && idx_q < len_q - 5'h02),
        .data    (tx_data_q),
        .crc_q   (tx_crc),
        .crc_d   (tx_crc_d)
    );

    // Register read mux; fault block sits on an aligned base
    function automatic logic [15:0] rd_word(input logic [15:0] a);
        if (a == `ADDR_CARRIER) begin
            rd_word = carrier_frequency_q;
        end else begin
            rd_word = fault_info[{a[2:0], 4'h0} +: 16];
        end
    endfunction

    // Qualify the frame and choose the exception code
    always_comb begin
        bcast     = buf_q[0] == `BCAST_ADDR;
        legal     = !keypad_q && (buf_q[0] == slave_address || bcast)
                 && cnt_q >= `MIN_LEN;
        crc_ok    = rx_crc == 16'h0000;
        len_ok    = cnt_q == `REQ_LEN;
        known     = func == `FC_READ || func == `FC_WRITE_NV
                 || func == `FC_LOOP || func == `FC_WRITE;
        valid     = legal && !bad_q && crc_ok && len_ok && known;
        fault_rng = reg_addr >= `ADDR_FAULT0 && {1'b0, reg_addr} < `ADDR_FAULT_END;
        exc_d     = `EX_NONE;
        if (bad_q || !crc_ok || !len_ok) begin
            exc_d = `EX_BAD_FRAME;
        end else begin
            unique case (func)
                `FC_READ: begin
                    if (!((reg_addr == `ADDR_CARRIER && reg_val == 16'h0001)
                        || (fault_rng && reg_val != 16'h0000
                        && ({1'b0, reg_addr} + {1'b0, reg_val}) <= `ADDR_FAULT_END))) begin
                        exc_d = `EX_ILL_ADDR;
                    end
                end
                `FC_WRITE_NV, `FC_WRITE: begin
                    if (func == `FC_WRITE && reg_addr == `ADDR_CMD) begin
                        // Only commands forward run through coast stop exist
                        if (reg_val < `CMD_FWD || reg_val > `CMD_COAST) begin
                            exc_d = `EX_RANGE;
                        end
                    end else if (func == `FC_WRITE && reg_addr == `ADDR_FREQ) begin
                        exc_d = `EX_NONE;
                    end else if (reg_addr == `ADDR_CARRIER) begin
                        exc_d = drive_running ? `EX_RUNNING : `EX_NONE;
                    end else if (fault_rng) begin
                        exc_d = `EX_READ_ONLY;
                    end else begin
                        exc_d = `EX_ILL_ADDR;
                    end
                end
                `FC_LOOP: begin
                    if (reg_addr != `LOOP_SUB) begin
                        exc_d = `EX_ILL_FUNC;
                    end
                end
                default: exc_d = `EX_ILL_FUNC;
            endcase
        end
    end

    // Receive buffer; bytes arriving while busy are dropped
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_q          <= 4'h0;
            gap_q          <= 4'h0;
            bad_q          <= 1'b0;
            keypad_q       <= 1'b0;
            rx_gap_fault_q <= 1'b0;
            for (int i = 0; i < 8; i++) begin
                buf_q[i] <= 8'h00;
            end
        end else if (ce) begin
            rx_gap_fault_q <= gap_fault;
            if (st_q != ST_RX) begin
                cnt_q    <= 4'h0;
                gap_q    <= 4'h0;
                bad_q    <= 1'b0;
                keypad_q <= 1'b0;
            end else if (rx_valid) begin
                if (cnt_q < `REQ_LEN) begin
                    buf_q[cnt_q[2:0]] <= rx_data;
                end
                if (cnt_q <= `REQ_LEN) begin
                    cnt_q <= cnt_q + 4'h1;
                end
                gap_q    <= 4'h0;
                bad_q    <= bad_q || gap_fault;
                keypad_q <= keypad_q || rx_from_keypad;
            end else if (ms_tick && cnt_q != 4'h0 && gap_q != 4'hF) begin
                gap_q <= gap_q + 4'h1;
            end
        end
    end

    // Main sequence
    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= ST_RX;
        end else if (ce) begin
            unique case (st_q)
                ST_RX:     if (eof) st_q <= ST_DECODE;
                ST_DECODE: begin
                    if (!legal) begin
                        st_q <= ST_RX;
                    end else if (exc_d == `EX_NONE && func == `FC_WRITE_NV) begin
                        st_q <= ST_NVWAIT;
                    end else begin
                        st_q <= bcast ? ST_RX : ST_DELAY;
                    end
                end
                ST_NVWAIT: if (nv_done) st_q <= bcast ? ST_RX : ST_DELAY;
                ST_DELAY:  if (dly_q >= dly_lim) st_q <= ST_SEND;
                ST_SEND:   if (hs && last) st_q <= ST_RX;
            endcase
        end
    end

    // Reply shape, fixed at decode, turned to exception on store failure
    always_ff @(posedge clk) begin
        if (reset) begin
            kind_q <= RP_ECHO;
            len_q  <= `REQ_LEN5;
            exc_q  <= `EX_NONE;
        end else if (ce) begin
            if (st_q == ST_DECODE) begin
                exc_q <= exc_d;
                if (exc_d != `EX_NONE) begin
                    kind_q <= RP_EXC;
                    len_q  <= `EXC_LEN;
                end else if (func == `FC_READ) begin
                    kind_q <= RP_READ;
                    len_q  <= `READ_OVERHEAD + {reg_val[3:0], 1'b0};
                end else begin
                    kind_q <= RP_ECHO;
                    len_q  <= `REQ_LEN5;
                end
            end else if (st_q == ST_NVWAIT && nv_done && nv_fail) begin
                kind_q <= RP_EXC;
                len_q  <= `EXC_LEN;
                exc_q  <= `EX_SLAVE_PROT;
            end
        end
    end

    // Reply delay counter in ms ticks; the first tick may be partial
    always_ff @(posedge clk) begin
        if (reset) begin
            dly_q <= 17'h00000;
        end else if (ce) begin
            if (st_q != ST_DELAY) begin
                dly_q <= 17'h00000;
            end else if (ms_tick) begin
                dly_q <= dly_q + 17'h00001;
            end
        end
    end

    // Next reply byte; check bytes come from the reply CRC, low first
    always_comb begin
        logic [4:0]  j;
        logic [4:0]  k;
        logic [15:0] w;
        j  = idx_q + 5'h01;
        k  = j - 5'h03;
        w  = rd_word(reg_addr + {12'h000, k[4:1]});
        nb = buf_q[j[2:0]];
        if (j == len_q - 5'h02) begin
            nb = tx_crc_d[7:0];
        end else if (j == len_q - 5'h01) begin
            nb = tx_crc[15:8];
        end else if (kind_q == RP_EXC) begin
            nb = (j == 5'h01) ? (func | `FC_EXC_BIT) : exc_q;
        end else if (kind_q == RP_READ && j == 5'h02) begin
            nb = {reg_val[6:0], 1'b0};
        end else if (kind_q == RP_READ && j > 5'h02) begin
            nb = k[0] ? w[7:0] : w[15:8];
        end
    end

    // Byte stream toward the UART
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_valid_q <= 1'b0;
            tx_data_q  <= 8'h00;
            idx_q      <= 5'h00;
        end else if (ce) begin
            if (st_q == ST_DELAY && dly_q >= dly_lim) begin
                tx_valid_q <= 1'b1;
                tx_data_q  <= buf_q[0];
                idx_q      <= 5'h00;
            end else if (hs) begin
                tx_valid_q <= !last;
                tx_data_q  <= nb;
                idx_q      <= last ? 5'h00 : idx_q + 5'h01;
            end
        end
    end

    // Register writes; function 0x41 never touches the store
    always_ff @(posedge clk) begin
        if (reset) begin
            drive_control_command_q <= 16'h0000;
            comm_set_frequency_q    <= 16'h0000;
            carrier_frequency_q     <= `CARRIER_RESET;
            cmd_strobe_q            <= 1'b0;
            comm_freq_in_use_q      <= 1'b0;
        end else if (ce) begin
            cmd_strobe_q       <= 1'b0;
            comm_freq_in_use_q <= main_frequency_source_select == `FREQ_SRC_COMM;
            if (st_q == ST_DECODE && legal && exc_d == `EX_NONE && func == `FC_WRITE) begin
                if (reg_addr == `ADDR_CMD) begin
                    drive_control_command_q <= reg_val;
                    cmd_strobe_q            <= 1'b1;
                end else if (reg_addr == `ADDR_FREQ) begin
                    comm_set_frequency_q <= reg_val;
                end else begin
                    carrier_frequency_q <= reg_val;
                end
            end else if (st_q == ST_NVWAIT && nv_done && !nv_fail) begin
                carrier_frequency_q <= nv_data_q;
            end
        end
    end

    // Nonvolatile store request, held until the store answers
    always_ff @(posedge clk) begin
        if (reset) begin
            nv_store_q <= 1'b0;
            nv_addr_q  <= 16'h0000;
            nv_data_q  <= 16'h0000;
        end else if (ce) begin
            if (st_q == ST_DECODE && legal && exc_d == `EX_NONE
                && func == `FC_WRITE_NV) begin
                nv_store_q <= 1'b1;
                nv_addr_q  <= reg_addr;
                nv_data_q  <= reg_val;
            end else if (nv_done) begin
                nv_store_q <= 1'b0;
            end
        end
    end

    // Silence watchdog between valid frames
    always_ff @(posedge clk) begin
        if (reset) begin
            to_cnt_q       <= 16'h0000;
            comm_timeout_q <= 1'b0;
        end else if (ce) begin
            if (st_q == ST_DECODE && valid) begin
                to_cnt_q <= 16'h0000;
            end else if (ms_tick && to_cnt_q != 16'hFFFF) begin
                to_cnt_q <= to_cnt_q + 16'h0001;
            end
            comm_timeout_q <= comm_timeout_setting != 16'h0000
                           && to_cnt_q > comm_timeout_setting;
        end
    end

    property p_exc_len;
        @(posedge clk) disable iff (reset)
        (ce && st_q == ST_DECODE && legal && exc_d != `EX_NONE) |=> len_q == `EXC_LEN;
    endproperty
    a_exc_len: assert property (p_exc_len) else $error("exception reply not five bytes");

    property p_exc_func;
        @(posedge clk) disable iff (reset)
        (kind_q == RP_EXC && tx_valid_q && idx_q == 5'h01) |-> tx_data_q == (func | `FC_EXC_BIT);
    endproperty
    a_exc_func: assert property (p_exc_func) else $error("exception function bit missing");

    property p_read_len;
        @(posedge clk) disable iff (reset)
        (ce && st_q == ST_DECODE && legal && exc_d == `EX_NONE && func == `FC_READ)
        |=> len_q == 5'(reg_val * 2 + 5);
    endproperty
    a_read_len: assert property (p_read_len) else $error("read reply length wrong");

    property p_echo;
        @(posedge clk) disable iff (reset)
        (kind_q == RP_ECHO && tx_valid_q && idx_q < 5'h06) |-> tx_data_q == buf_q[idx_q[2:0]];
    endproperty
    a_echo: assert property (p_echo) else $error("echo byte differs");

    property p_ignore;
        @(posedge clk) disable iff (reset)
        (ce && st_q == ST_DECODE && (!legal || bcast)) |=> st_q != ST_DELAY;
    endproperty
    a_ignore: assert property (p_ignore) else $error("reply to ignored frame");

    property p_delay;
        @(posedge clk) disable iff (reset)
        $rose(tx_valid_q) |-> $past(dly_q) >= $past(dly_lim);
    endproperty
    a_delay: assert property (p_delay) else $error("reply sent too early");

    property p_timeout_off;
        @(posedge clk) disable iff (reset)
        (ce && comm_timeout_setting == 16'h0000) |=> !comm_timeout_q;
    endproperty
    a_timeout_off: assert property (p_timeout_off) else $error("timeout with check off");

    property p_cmd;
        @(posedge clk) disable iff (reset)
        cmd_strobe_q |-> $past(func) == `FC_WRITE && drive_control_command_q == $past(reg_val);
    endproperty
    a_cmd: assert property (p_cmd) else $error("command strobe without write");

    property p_nv;
        @(posedge clk) disable iff (reset)
        $rose(nv_store_q) |-> $past(st_q) == ST_DECODE && $past(func) == `FC_WRITE_NV;
    endproperty
    a_nv: assert property (p_nv) else $error("store request without function 0x06");
endmodule

/* tb/master.sv */
// Modbus master station model: sends frames, takes replies, answers stores
`timescale 1ns/1ps
module master (
    input  wire logic       clk,
    input  wire logic       tx_valid_q,
    input  wire logic [7:0] tx_data_q,
    input  wire logic       nv_store_q,
    output logic            rx_valid,
    output logic      [7:0] rx_data,
    output logic            rx_from_keypad,
    output logic            tx_ready,
    output logic            nv_done,
    output logic            nv_fail
);
    logic [7:0] got[$];   // Reply bytes in order
    logic [2:0] cyc;      // Stall phase
    logic       fail_next; // Next store fails
    initial begin
        {rx_valid, rx_data, rx_from_keypad, tx_ready, nv_done, nv_fail, fail_next, cyc} = '0;
    end
    // Stall two cycles in eight; slow store keeps the reply waiting
    always @(negedge clk) begin
        cyc <= cyc + 3'h1;
        tx_ready <= (cyc != 3'h2) && (cyc != 3'h3);
        nv_done <= nv_store_q && !nv_done && (cyc == 3'h7);
        nv_fail <= nv_store_q && fail_next && (cyc == 3'h7);
    end
    // Byte counts only at an edge where both sides agree
    always @(posedge clk) begin
        if (tx_valid_q && tx_ready) got.push_back(tx_data_q);
    end
    // Bytes back to back, CRC low first; idle line shows inverted data
    task automatic send(input logic [135:0] v, input int n, input logic kp);
        for (int k = 0; k < n; k++) begin
            @(negedge clk);
            rx_valid = 1'b1;
            rx_data = v[135-8*k -: 8];
            rx_from_keypad = kp;
        end
        @(negedge clk);
        rx_valid = 1'b0;
        rx_from_keypad = 1'b0;
        rx_data = ~rx_data;
    endtask
endmodule

/* tb/tb.sv */
// Self-checking bench for the RTU slave frame handler
`timescale 1ns/1ps
module tb;
    typedef struct { logic [63:0] req; logic [15:0] val; } row_t;
    logic        clk = 1'b0;     // 100 MHz
    logic        reset = 1'b1;   // Sync reset
    logic        ms_tick = 1'b0; // Shortened millisecond
    logic [4:0]  tcnt = '0;      // Tick divider
    logic        rx_valid, rx_from_keypad, tx_ready, nv_done, nv_fail;
    logic [7:0]  rx_data, tx_data_q;
    logic        tx_valid_q, nv_store_q, comm_freq_in_use_q, comm_timeout_q;
    logic [15:0] carrier_frequency_q, drive_control_command_q, comm_set_frequency_q;
    logic        ce = 1'b1;              // Clock enable, dropped once to test freezing
    logic        drive_running = 1'b0;   // Drive state seen by carrier writes
    logic [3:0]  freq_src = 4'h7;        // Main frequency source select
    logic [15:0] timeout_set = 16'h0028; // Silence limit in ms, zero turns it off
    int          n_errors = 0;
    int          checks_done = 0;
    // Echo frames and the register each should leave behind
    row_t rows[4] = '{'{64'h014170000001E6C5, 16'h0001}, '{64'h01417000000766C7, 16'h0007},
                      '{64'h0141701513883B97, 16'h1388}, '{64'h01080000AA555E94, 16'h0007}};
    always #5 clk = ~clk;
    // One tick every 20 cycles keeps frame gaps short
    always @(negedge clk) begin
        tcnt <= (tcnt == 5'h13) ? 5'h00 : tcnt + 5'h01;
        ms_tick <= (tcnt == 5'h13);
    end
    modbus_rtu_slave_frames modbus_rtu_slave_frames_i (.clk(clk), .reset(reset), .ce(ce),
        .rx_valid(rx_valid), .rx_data(rx_data), .rx_from_keypad(rx_from_keypad),
        .ms_tick(ms_tick), .slave_address(8'h01), .eof_gap_ms(4'h3), .fault_gap_ms(4'h2),
        .comm_timeout_setting(timeout_set), .response_delay_setting(16'h0000),
        .main_frequency_source_select(freq_src), .drive_running(drive_running),
        .fault_info({16'h0000, 16'h0000, 16'h012C, 16'h0000, 16'h0000, 16'h0011}),
        .nv_done(nv_done), .nv_fail(nv_fail), .tx_ready(tx_ready), .tx_valid_q(tx_valid_q),
        .tx_data_q(tx_data_q), .nv_store_q(nv_store_q), .nv_addr_q(), .nv_data_q(),
        .carrier_frequency_q(carrier_frequency_q), .cmd_strobe_q(),
        .drive_control_command_q(drive_control_command_q), .rx_gap_fault_q(),
        .comm_set_frequency_q(comm_set_frequency_q), .comm_freq_in_use_q(comm_freq_in_use_q),
        .comm_timeout_q(comm_timeout_q));
    master master_i (.clk(clk), .tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q),
        .nv_store_q(nv_store_q), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_from_keypad(rx_from_keypad), .tx_ready(tx_ready), .nv_done(nv_done),
        .nv_fail(nv_fail));
    // Append CRC-16 after n left-aligned bytes, low byte first
    function automatic logic [135:0] wc(input logic [135:0] v, input int n);
        logic [15:0] c;
        c = 16'hFFFF;
        for (int k = 0; k < n; k++) begin
            c ^= {8'h00, v[135-8*k -: 8]};
            repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
        end
        v[135-8*n -: 8] = c[7:0];
        v[127-8*n -: 8] = c[15:8];
        return v;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One request, then the whole reply byte by byte; m of zero means silence
    task automatic xf(input logic [135:0] req, input int n, input logic [135:0] exp,
                      input int m, input logic kp);
        master_i.got.delete();
        master_i.send(req, n, kp);
        for (int w = 0; w < 1500 && (master_i.got.size() < m || tx_valid_q !== 1'b0); w++)
            @(negedge clk);
        if (m == 0) repeat (600) @(negedge clk);
        chk(16'(master_i.got.size()), 16'(m));
        foreach (master_i.got[k]) if (k < m) chk({8'h00, master_i.got[k]}, {8'h00, exp[135-8*k -: 8]});
        repeat (50) @(negedge clk);
    endtask
    task automatic conclude();
        $display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Hang guard well past the expected run
    initial begin
        #400000;
        n_errors++;
        conclude();
    end
    initial begin
        repeat (6) @(negedge clk);
        reset = 1'b0;
        chk({15'h0000, tx_valid_q}, 16'h0000);
        chk(carrier_frequency_q, 16'h0000);
        foreach (rows[i]) begin
            xf({rows[i].req, 72'h0}, 8, {rows[i].req, 72'h0}, 8, 1'b0);
            chk(i == 2 ? comm_set_frequency_q : drive_control_command_q, rows[i].val);
        end
        chk({15'h0000, comm_freq_in_use_q}, 16'h0001);
        xf({64'h010313000006C14C, 72'h0}, 8, 136'h01030C001100000000012C00000000535B, 17, 1'b0);
        xf({64'h014170000001E6C4, 72'h0}, 8, wc({24'h01C103, 112'h0}, 3), 5, 1'b0);
        xf(wc({48'h014270000001, 88'h0}, 6), 8, wc({24'h01C201, 112'h0}, 3), 5, 1'b0);
        master_i.fail_next = 1'b1;
        xf({64'h01060017002839D0, 72'h0}, 8, {40'h01860443A3, 96'h0}, 5, 1'b0);
        master_i.fail_next = 1'b0;
        xf({64'h01060017002839D0, 72'h0}, 8, {64'h01060017002839D0, 72'h0}, 8, 1'b0);
        chk(carrier_frequency_q, 16'h0028);
        chk({15'h0000, comm_timeout_q}, 16'h0000);
        xf(wc({48'h024170000001, 88'h0}, 6), 8, 136'h0, 0, 1'b0);
        xf({rows[0].req, 72'h0}, 8, 136'h0, 0, 1'b1);
        chk({15'h0000, comm_timeout_q}, 16'h0001);
        // Zero setting switches the silence check off
        timeout_set = 16'h0000;
        repeat (3) @(negedge clk);
        chk({15'h0000, comm_timeout_q}, 16'h0000);
        // Carrier write refused while the drive runs
        drive_running = 1'b1;
        xf(wc({48'h014100170028, 88'h0}, 6), 8, wc({24'h01C107, 112'h0}, 3), 5, 1'b0);
        drive_running = 1'b0;
        // Other frequency source: set frequency no longer in use
        freq_src = 4'h0;
        repeat (3) @(negedge clk);
        chk({15'h0000, comm_freq_in_use_q}, 16'h0000);
        // Frozen block takes no bytes, so the command stays as it was
        ce = 1'b0;
        xf({rows[0].req, 72'h0}, 8, 136'h0, 0, 1'b0);
        ce = 1'b1;
        chk(drive_control_command_q, 16'h0007);
        conclude();
    end
endmodule
